// File: inc/core_regs_pkg.sv
package core_regs_pkg;

    // ------------------------------------------------------------
    // register indices on the plain register port
    // ------------------------------------------------------------
    localparam int          ADDR_W          = 3;
    localparam logic [2:0]  IDX_PROG_CNT    = 3'h0;
    localparam logic [2:0]  IDX_ACCUM       = 3'h1;
    localparam logic [2:0]  IDX_SECOND_ACC  = 3'h2;
    localparam logic [2:0]  IDX_INDEX       = 3'h3;
    localparam logic [2:0]  IDX_EXTRA_PTR   = 3'h4;
    localparam logic [2:0]  IDX_STACK_PTR   = 3'h5;
    localparam logic [2:0]  IDX_PROG_STATUS = 3'h6;

    // ------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------
    localparam int           WORD_W       = 16;
    localparam int           BYTE_W       = 8;
    localparam logic [15:0]  COUNTER_RESET = 16'hFFFD;
    localparam logic [1:0]   LEVEL_RESET  = 2'h3;
    localparam logic [15:0]  ZERO_WORD    = 16'h0000;
    localparam logic [7:0]   ZERO_BYTE    = 8'h00;

    // ------------------------------------------------------------
    // condition code byte field positions
    // ------------------------------------------------------------
    localparam int  CC_HALF   = 7;
    localparam int  CC_IEN    = 6;
    localparam int  CC_LVL_HI = 5;
    localparam int  CC_LVL_LO = 4;
    localparam int  CC_NEG    = 3;
    localparam int  CC_ZERO   = 2;
    localparam int  CC_OVF    = 1;
    localparam int  CC_CARRY  = 0;

    // ------------------------------------------------------------
    // general-purpose bank geometry
    // ------------------------------------------------------------
    localparam int  REGS_PER_BANK = 8;
    localparam int  SEL_W         = 3;
    localparam int  BANK_W        = 4;
    localparam int  MAX_BANKS     = 16;

    // byte-wide operations applied to the accumulator low byte
    typedef enum logic [2:0] {
        OP_NONE,
        OP_ADD,
        OP_SUB,
        OP_SHL,
        OP_SHR
    } alu_op_type;

endpackage

// File: rtl/core_regs.sv
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
// Operation
// - sixteen-bit program counter holds fetch address
// - sixteen-bit accumulator, byte ops use low byte
// - temporary accumulator is second operand, low byte
// - sixteen-bit index register for indexed addressing
// - sixteen-bit extra pointer as operand address
// - sixteen-bit stack pointer locates stack area
// - status word: bank pointer high, codes low
// - bank pointer steers register-operand RAM addresses
// - half-carry tracks carry/borrow bit three to four
// - interrupts accepted only while enable flag set
// - reset clears interrupt enable flag
// - serve request only above current level field
// - negative flag mirrors result top bit
// - zero flag set exactly for zero result
// - overflow flag marks two's complement overflow
// - carry flag marks carry/borrow out of bit seven
// - shifts load shifted-out bit into carry
// - general registers are bytes in RAM
// - eight registers per bank, up to sixteen banks
module core_regs
    import core_regs_pkg::*;
#(
    parameter int           BANK_COUNT = 16,      // usable banks, set by RAM size
    parameter logic [15:0]  BANK_BASE  = 16'h0100 // RAM address of bank zero
) (
    // clock and reset
    input  wire logic               clk_in,
    input  wire logic               rst_n_in,
    // register port
    input  wire logic [ADDR_W-1:0]  reg_addr_in,
    input  wire logic [WORD_W-1:0]  reg_wdata_in,
    input  wire logic               reg_wr_in,
    input  wire logic               reg_rd_in,
    output logic      [WORD_W-1:0]  reg_rdata_out,
    // byte-wide alu operation
    input  wire alu_op_type         alu_op_in,
    // interrupt request from the controller
    input  wire logic               irq_req_in,
    input  wire logic [1:0]         irq_level_in,
    output logic                    irq_take_out,
    // general register addressing
    input  wire logic [SEL_W-1:0]   gp_sel_in,
    output logic      [WORD_W-1:0]  gp_addr_out,
    // dedicated register values toward the datapath
    output logic      [WORD_W-1:0]  program_counter_out,
    output logic      [WORD_W-1:0]  index_register_out,
    output logic      [WORD_W-1:0]  extra_pointer_out,
    output logic      [WORD_W-1:0]  stack_pointer_out,
    output logic      [WORD_W-1:0]  program_status_out
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (BANK_COUNT < 1 || BANK_COUNT > MAX_BANKS) begin : g_bank_check
        $error("bank count must lie between one and sixteen");
    end

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [WORD_W-1:0] main_accumulator;    // arithmetic result holder
    logic [WORD_W-1:0] second_operand_acc;  // second operand
    logic [BYTE_W-1:0] bank_pointer;        // upper status byte
    logic [BYTE_W-1:0] condition_code_byte; // lower status byte
    logic [WORD_W-1:0] status_word;         // both halves joined

    // flag results of the current alu operation
    logic [BYTE_W-1:0] next_result;
    logic              next_half;
    logic              next_carry;
    logic              next_ovf;
    logic              flags_update;        // an operation is present
    logic [BYTE_W:0]   wide_sum;            // nine-bit sum or difference
    logic [BYTE_W-1:0] op_a;                // accumulator low byte
    logic [BYTE_W-1:0] op_b;                // second operand low byte
    logic              level_ok;            // request outranks level field

    assign status_word = {bank_pointer, condition_code_byte};
    assign op_a        = main_accumulator[BYTE_W-1:0];
    assign op_b        = second_operand_acc[BYTE_W-1:0];

    // ------------------------------------------------------------
    // byte alu flag logic
    // ------------------------------------------------------------
    // flags come from the low bytes only; upper bytes are untouched
    always_comb begin
        wide_sum     = {1'b0, op_a} + {1'b0, op_b};
        next_result  = op_a;
        next_half    = condition_code_byte[CC_HALF];
        next_carry   = condition_code_byte[CC_CARRY];
        next_ovf     = condition_code_byte[CC_OVF];
        flags_update = 1'b1;
        unique case (alu_op_in)
            OP_ADD: begin
                next_result = wide_sum[BYTE_W-1:0];
                next_carry  = wide_sum[BYTE_W];
                next_half   = (({1'b0, op_a[3:0]} + {1'b0, op_b[3:0]}) > 5'h0F);
                next_ovf    = (op_a[7] == op_b[7]) && (next_result[7] != op_a[7]);
            end
            OP_SUB: begin
                wide_sum    = {1'b0, op_a} - {1'b0, op_b};
                next_result = wide_sum[BYTE_W-1:0];
                next_carry  = wide_sum[BYTE_W];
                next_half   = (op_a[3:0] < op_b[3:0]);
                next_ovf    = (op_a[7] != op_b[7]) && (next_result[7] != op_a[7]);
            end
            OP_SHL: begin
                next_result = {op_a[6:0], 1'b0};
                next_carry  = op_a[7];
            end
            OP_SHR: begin
                next_result = {1'b0, op_a[7:1]};
                next_carry  = op_a[0];
            end
            OP_NONE: begin
                flags_update = 1'b0;
            end
            default: begin
                // spare op encodings do nothing, so a glitching op field
                // cannot disturb the flags
                flags_update = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // program counter
    // ------------------------------------------------------------
    // loaded by the sequencer through the register port
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            program_counter_out <= COUNTER_RESET;
        end else if (reg_wr_in && reg_addr_in == IDX_PROG_CNT) begin
            program_counter_out <= reg_wdata_in;
        end
    end

    // ------------------------------------------------------------
    // accumulator
    // ------------------------------------------------------------
    // no reset: contents are undefined after reset
    always_ff @(posedge clk_in) begin
        if (reg_wr_in && reg_addr_in == IDX_ACCUM) begin
            main_accumulator <= reg_wdata_in;
        end else if (flags_update) begin
            main_accumulator[BYTE_W-1:0] <= next_result;
        end
    end

    // ------------------------------------------------------------
    // pointer registers and second operand
    // ------------------------------------------------------------
    // none of these are reset, the core must load them first
    always_ff @(posedge clk_in) begin
        if (reg_wr_in) begin
            unique case (reg_addr_in)
                IDX_SECOND_ACC: second_operand_acc <= reg_wdata_in;
                IDX_INDEX:      index_register_out <= reg_wdata_in;
                IDX_EXTRA_PTR:  extra_pointer_out  <= reg_wdata_in;
                IDX_STACK_PTR:  stack_pointer_out  <= reg_wdata_in;
                default: begin
                    // other mapped indices are held elsewhere
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // program status: bank pointer and condition codes
    // ------------------------------------------------------------
    // a port write beats a simultaneous alu flag update so software
    // restoring the status word is never corrupted
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            bank_pointer        <= ZERO_BYTE;
            condition_code_byte <= ZERO_BYTE;
            condition_code_byte[CC_IEN] <= 1'b0;
            condition_code_byte[CC_LVL_HI:CC_LVL_LO] <= LEVEL_RESET;
        end else if (reg_wr_in && reg_addr_in == IDX_PROG_STATUS) begin
            bank_pointer        <= reg_wdata_in[WORD_W-1:BYTE_W];
            condition_code_byte <= reg_wdata_in[BYTE_W-1:0];
        end else if (flags_update) begin
            condition_code_byte[CC_HALF]  <= next_half;
            condition_code_byte[CC_NEG]   <= next_result[7];
            condition_code_byte[CC_ZERO]  <= (next_result == ZERO_BYTE);
            condition_code_byte[CC_OVF]   <= next_ovf;
            condition_code_byte[CC_CARRY] <= next_carry;
        end
    end

    // status word mirror toward the datapath
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            program_status_out <= ZERO_WORD;
        end else begin
            program_status_out <= status_word;
        end
    end

    // ------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------
    // data stands only in the cycle after the strobe, zero otherwise
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= ZERO_WORD;
        end else if (reg_rd_in) begin
            unique case (reg_addr_in)
                IDX_PROG_CNT:    reg_rdata_out <= program_counter_out;
                IDX_ACCUM:       reg_rdata_out <= main_accumulator;
                IDX_SECOND_ACC:  reg_rdata_out <= second_operand_acc;
                IDX_INDEX:       reg_rdata_out <= index_register_out;
                IDX_EXTRA_PTR:   reg_rdata_out <= extra_pointer_out;
                IDX_STACK_PTR:   reg_rdata_out <= stack_pointer_out;
                IDX_PROG_STATUS: reg_rdata_out <= status_word;
                default:         reg_rdata_out <= ZERO_WORD; // unmapped
            endcase
        end else begin
            reg_rdata_out <= ZERO_WORD;
        end
    end

    // ------------------------------------------------------------
    // interrupt acceptance
    // ------------------------------------------------------------
    // lower code means higher priority, so strictly less wins
    assign level_ok = irq_level_in < condition_code_byte[CC_LVL_HI:CC_LVL_LO];

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            irq_take_out <= 1'b0;
        end else begin
            irq_take_out <= irq_req_in && condition_code_byte[CC_IEN] && level_ok;
        end
    end

    // ------------------------------------------------------------
    // general register address generation
    // ------------------------------------------------------------
    // bytes live in RAM, eight per bank; the bank field wraps onto
    // the usable banks because smaller RAMs hold fewer of them
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            gp_addr_out <= BANK_BASE;
        end else begin
            gp_addr_out <= BANK_BASE + WORD_W'((32'(bank_pointer[BANK_W-1:0]) % BANK_COUNT)
                           * REGS_PER_BANK) + WORD_W'(gp_sel_in);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    counter_reset_a: assert property (@(posedge clk_in)
        !rst_n_in |=> program_counter_out == COUNTER_RESET && program_status_out == ZERO_WORD)
        else $error("counter not FFFD after reset");

    ien_reset_a: assert property (@(posedge clk_in)
        !rst_n_in |=> !condition_code_byte[CC_IEN] &&
                     condition_code_byte[CC_LVL_HI:CC_LVL_LO] == LEVEL_RESET)
        else $error("enable or level wrong after reset");

    irq_gate_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        irq_take_out |-> $past(condition_code_byte[CC_IEN]) && $past(irq_req_in))
        else $error("interrupt taken while disabled");

    irq_level_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        irq_req_in && condition_code_byte[CC_IEN] &&
        irq_level_in < condition_code_byte[CC_LVL_HI:CC_LVL_LO] |=> irq_take_out)
        else $error("eligible interrupt not taken");

    zero_flag_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        alu_op_in != OP_NONE && !reg_wr_in |=>
        condition_code_byte[CC_ZERO] == (main_accumulator[BYTE_W-1:0] == ZERO_BYTE))
        else $error("zero flag disagrees with result");

    neg_flag_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        alu_op_in != OP_NONE && !reg_wr_in |=>
        condition_code_byte[CC_NEG] == main_accumulator[7])
        else $error("negative flag disagrees with result");

    add_carry_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        alu_op_in == OP_ADD && !reg_wr_in |=>
        condition_code_byte[CC_CARRY] == ((9'($past(op_a)) + 9'($past(op_b))) > 9'h0FF))
        else $error("carry wrong after add");

    half_carry_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        alu_op_in == OP_SUB && !reg_wr_in |=>
        condition_code_byte[CC_HALF] == ($past(op_a[3:0]) < $past(op_b[3:0])))
        else $error("half carry wrong after subtract");

    shift_carry_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        alu_op_in == OP_SHR && !reg_wr_in |=> condition_code_byte[CC_CARRY] == $past(op_a[0]))
        else $error("shift-out bit not in carry");

    upper_byte_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        alu_op_in != OP_NONE && !reg_wr_in |=>
        main_accumulator[WORD_W-1:BYTE_W] == $past(main_accumulator[WORD_W-1:BYTE_W]))
        else $error("byte operation touched upper byte");

    read_latency_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !reg_rd_in |=> reg_rdata_out == ZERO_WORD)
        else $error("read data outside its cycle");

endmodule // core_regs

// File: tb/seq_model.sv
`timescale 1ns/1ps
// ------------------------------------------------
// sequencer and alu-side driver of the register block
// ------------------------------------------------
module seq_model
    import core_regs_pkg::*;
(
    // clock
    input  wire logic              clk_in,
    // requests toward the register block
    output alu_op_type             alu_op_out,
    output logic                   irq_req_out,
    output logic [1:0]             irq_level_out,
    output logic [SEL_W-1:0]       gp_sel_out,
    // tells the bench a new bank lookup was issued
    output logic                   sel_mark_out
);
    // every request changes just after a rising edge
    task automatic drive(input alu_op_type op, input logic req, input logic [1:0] lvl,
                         input logic [SEL_W-1:0] sel, input logic mark);
        @(posedge clk_in);
        alu_op_out    <= op;
        irq_req_out   <= req;
        // an unused level is not left at its last value
        irq_level_out <= req ? lvl : ~irq_level_out;
        gp_sel_out    <= sel;
        sel_mark_out  <= mark;
    endtask

    // quiet at time zero
    initial begin
        alu_op_out    = OP_NONE;
        irq_req_out   = 1'b0;
        irq_level_out = 2'h0;
        gp_sel_out    = 3'h0;
        sel_mark_out  = 1'b0;
    end
endmodule // seq_model

// File: tb/core_regs_tb.sv
`timescale 1ns/1ps
module core_regs_tb;
    import core_regs_pkg::*;
    // ------------------------------------------------
    // signals
    // ------------------------------------------------
    logic              clk_in;
    logic              rst_n_in;
    logic [ADDR_W-1:0] reg_addr_in;
    logic [WORD_W-1:0] reg_wdata_in;
    logic              reg_wr_in;
    logic              reg_rd_in;
    logic [WORD_W-1:0] reg_rdata_out;
    alu_op_type        alu_op_in;
    alu_op_type        op1, op2;
    logic              irq_req_in;
    logic [1:0]        irq_level_in;
    logic              irq_take_out;
    logic [SEL_W-1:0]  gp_sel_in;
    logic              sel_mark;
    logic [WORD_W-1:0] gp_addr_out, counter_val, index_val, extra_val, stack_val, status_val;
    int                errors, check_count, seed, i, j;
    logic [15:0]       rd_q[$];          // expected read data, oldest first
    logic [15:0]       gp_q[$];          // expected bank addresses
    logic              irq_q[$];         // expected interrupt decisions
    logic              rd_seen, irq_seen, sel_seen;
    logic [15:0]       shadow[0:5];
    logic [15:0]       a, opnd, r1, r2;
    logic [7:0]        cc;

    core_regs #(.BANK_COUNT(16), .BANK_BASE(16'h0100)) dut_u (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .alu_op_in(alu_op_in), .irq_req_in(irq_req_in),
        .irq_level_in(irq_level_in), .irq_take_out(irq_take_out), .gp_sel_in(gp_sel_in),
        .gp_addr_out(gp_addr_out), .program_counter_out(counter_val),
        .index_register_out(index_val), .extra_pointer_out(extra_val),
        .stack_pointer_out(stack_val), .program_status_out(status_val));

    seq_model model_u (.clk_in(clk_in), .alu_op_out(alu_op_in), .irq_req_out(irq_req_in),
        .irq_level_out(irq_level_in), .gp_sel_out(gp_sel_in), .sel_mark_out(sel_mark));

    // 20 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end

    // ------------------------------------------------
    // tasks
    // ------------------------------------------------
    task automatic cmp16(input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    task automatic cmp1(input logic exp, input logic got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    // one bus cycle; for a read, d is the expected data and is queued
    task automatic bus(input logic wr, input logic rd, input logic [2:0] ad,
                       input logic [15:0] d);
        @(posedge clk_in);
        reg_wr_in    <= wr;
        reg_rd_in    <= rd;
        reg_addr_in  <= ad;
        reg_wdata_in <= d;
        if (rd) rd_q.push_back(d);
    endtask
    task automatic do_reset;
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        repeat (6) @(posedge clk_in);
        rst_n_in <= 1'b1;
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // byte alu reference: {result, condition codes}
    function automatic logic [15:0] alu_exp(input alu_op_type op, input logic [7:0] a8,
                                            input logic [7:0] t8, input logic [7:0] f);
        logic [8:0] s;
        logic [7:0] g;
        g = f;
        s = (op == OP_SUB) ? {1'b0, a8} - {1'b0, t8} : {1'b0, a8} + {1'b0, t8};
        if (op == OP_SHL) s = {a8, 1'b0};
        if (op == OP_SHR) s = {a8[0], 1'b0, a8[7:1]};
        g[CC_CARRY] = s[8];
        if (op == OP_ADD) g[CC_HALF] = ({1'b0, a8[3:0]} + {1'b0, t8[3:0]}) > 5'h0F;
        if (op == OP_SUB) g[CC_HALF] = a8[3:0] < t8[3:0];
        if (op == OP_ADD) g[CC_OVF] = (a8[7] == t8[7]) && (s[7] != a8[7]);
        if (op == OP_SUB) g[CC_OVF] = (a8[7] != t8[7]) && (s[7] != a8[7]);
        g[CC_NEG]  = s[7];
        g[CC_ZERO] = (s[7:0] == 8'h00);
        return {s[7:0], g};
    endfunction

    // ------------------------------------------------
    // result watcher: answers land one cycle after the request
    // ------------------------------------------------
    always @(posedge clk_in) begin
        rd_seen  <= reg_rd_in;
        irq_seen <= irq_req_in;
        sel_seen <= sel_mark;
    end
    always @(negedge clk_in) begin
        if (rd_seen === 1'b1 && rd_q.size() > 0) cmp16(rd_q.pop_front(), reg_rdata_out);
        if (irq_seen === 1'b1 && irq_q.size() > 0) cmp1(irq_q.pop_front(), irq_take_out);
        if (sel_seen === 1'b1 && gp_q.size() > 0) cmp16(gp_q.pop_front(), gp_addr_out);
    end

    // watchdog, far beyond the expected run length
    initial begin
        repeat (5000) @(posedge clk_in);
        errors++;
        complete_run;
    end

    // ------------------------------------------------
    // main sequence
    // ------------------------------------------------
    initial begin
        seed = 27799;
        errors = 0;
        check_count = 0;
        rst_n_in = 1'b0;
        reg_addr_in = 3'h0;
        reg_wdata_in = 16'h0000;
        reg_wr_in = 1'b0;
        reg_rd_in = 1'b0;
        do_reset;
        bus(0, 1, IDX_PROG_CNT, COUNTER_RESET);
        bus(0, 1, IDX_PROG_STATUS, 16'h0030);
        bus(0, 0, 3'h0, 16'h0000);
        irq_q.push_back(1'b0);
        model_u.drive(OP_NONE, 1'b1, 2'h0, 3'h0, 1'b0);
        model_u.drive(OP_NONE, 1'b0, 2'h0, 3'h0, 1'b0);
        @(negedge clk_in);
        cmp16(16'h0030, status_val);
        $display("test reset finished");
        // the six words below status written and read back to back, unmapped slot ignored
        for (i = 0; i < 6; i++) begin
            shadow[i] = 16'($random(seed));
            bus(1, 0, i[2:0], shadow[i]);
        end
        bus(1, 0, 3'h7, 16'hFFFF);
        for (i = 0; i < 6; i++) bus(0, 1, i[2:0], shadow[i]);
        bus(0, 1, 3'h7, 16'h0000);
        bus(0, 0, 3'h0, 16'h0000);
        @(negedge clk_in);
        cmp16(shadow[0], counter_val);
        cmp16(shadow[3], index_val);
        cmp16(shadow[4], extra_val);
        cmp16(shadow[5], stack_val);
        do_reset;
        bus(0, 1, IDX_PROG_CNT, COUNTER_RESET);
        bus(0, 1, IDX_PROG_STATUS, 16'h0030);
        $display("test words finished");
        // two back-to-back alu ops, every pairing of the four ops
        for (i = 0; i < 40; i++) begin
            a = 16'($random(seed));
            opnd = 16'($random(seed));
            cc = 8'($random(seed));
            if (i == 0) a = 16'h12FF;
            if (i == 0) opnd = 16'h0001;
            op1 = alu_op_type'(1 + i % 4);
            op2 = alu_op_type'(1 + (i / 4) % 4);
            r1 = alu_exp(op1, a[7:0], opnd[7:0], cc);
            r2 = alu_exp(op2, r1[15:8], opnd[7:0], r1[7:0]);
            bus(1, 0, IDX_ACCUM, a);
            bus(1, 0, IDX_SECOND_ACC, opnd);
            bus(1, 0, IDX_PROG_STATUS, {8'(i), cc});
            bus(0, 0, 3'h0, 16'h0000);
            model_u.drive(op1, 1'b0, 2'h0, 3'h0, 1'b0);
            model_u.drive(op2, 1'b0, 2'h0, 3'h0, 1'b0);
            model_u.drive(OP_NONE, 1'b0, 2'h0, 3'h0, 1'b0);
            bus(0, 1, IDX_ACCUM, {a[15:8], r2[15:8]});
            bus(0, 1, IDX_PROG_STATUS, {8'(i), r2[7:0]});
            bus(0, 1, IDX_SECOND_ACC, opnd);
            bus(0, 0, 3'h0, 16'h0000);
        end
        $display("test alu finished");
        // every enable, level field and request level
        for (i = 0; i < 32; i++) begin
            bus(1, 0, IDX_PROG_STATUS, {8'h00, 1'b0, i[4], i[3:2], 4'h0});
            bus(0, 0, 3'h0, 16'h0000);
            irq_q.push_back(i[4] && (i[1:0] < i[3:2]));
            model_u.drive(OP_NONE, 1'b1, i[1:0], 3'h0, 1'b0);
            model_u.drive(OP_NONE, 1'b0, 2'h0, 3'h0, 1'b0);
        end
        $display("test interrupt finished");
        // every bank with a random register number
        for (i = 0; i < 32; i++) begin
            j = $random(seed);
            bus(1, 0, IDX_PROG_STATUS, {j[7:4], i[3:0], 8'h00});
            bus(0, 0, 3'h0, 16'h0000);
            gp_q.push_back(16'h0100 + 16'(i[3:0]) * 16'h0008 + 16'(j[2:0]));
            model_u.drive(OP_NONE, 1'b0, 2'h0, j[2:0], 1'b1);
            model_u.drive(OP_NONE, 1'b0, 2'h0, j[2:0], 1'b0);
        end
        @(negedge clk_in);
        cmp16({j[7:4], 4'hF, 8'h00}, status_val);
        $display("test bank finished");
        complete_run;
    end
endmodule // core_regs_tb
